// >>> design/sensor_spi_pkg.sv
// shared constants and helpers for the sensor serial slave
package sensor_spi_pkg;
  localparam int          FRAME_BITS  = 16;
  localparam int          DATA_W      = 14;
  localparam int          CNT_W       = 5;
  localparam int          CFG_WORDS   = 5;
  localparam int          SYNC_STAGES = 3;

  // frame field positions
  localparam int          BIT_PARITY  = 15;
  localparam int          BIT_DIR     = 14;

  // fault status register bit positions
  localparam int          FAULT_W      = 3;
  localparam int          FAULT_PARITY = 2;
  localparam int          FAULT_ADDR   = 1;
  localparam int          FAULT_FRAME  = 0;

  // register addresses
  localparam logic [13:0] ADDR_NOP      = 14'h0000;
  localparam logic [13:0] ADDR_FAULT    = 14'h0001;
  localparam logic [13:0] ADDR_PROG     = 14'h0003;
  localparam logic [13:0] ADDR_ZERO_HI  = 14'h0016;
  localparam logic [13:0] ADDR_ZERO_LO  = 14'h0017;
  localparam logic [13:0] ADDR_SET1     = 14'h0018;
  localparam logic [13:0] ADDR_SET2     = 14'h0019;
  localparam logic [13:0] ADDR_DIAG     = 14'h3ffc;
  localparam logic [13:0] ADDR_MAG      = 14'h3ffd;
  localparam logic [13:0] ADDR_ANG_RAW  = 14'h3ffe;
  localparam logic [13:0] ADDR_ANG_COMP = 14'h3fff;

  // storage slots of the writable registers
  localparam logic [2:0]  IDX_PROG    = 3'h0;
  localparam logic [2:0]  IDX_ZERO_HI = 3'h1;
  localparam logic [2:0]  IDX_ZERO_LO = 3'h2;
  localparam logic [2:0]  IDX_SET1    = 3'h3;
  localparam logic [2:0]  IDX_SET2    = 3'h4;

  // values after reset
  localparam logic [13:0] RST_SET1    = 14'h0001;
  localparam logic [13:0] RST_CFG     = 14'h0000;
  localparam logic [15:0] RST_TX      = 16'h0000;
  localparam logic [2:0]  RST_SYNC_HI = 3'h7;

  // even parity bit over the lower fifteen bits of a frame
  function automatic logic parity15(input logic [14:0] v);
    return ^v;
  endfunction
endpackage

// >>> design/sensor_spi_if.sv
// carriers between the serial core, its link end and its register bank
`timescale 1ns/1ps
interface frame_if;
  logic [15:0] rx_word;
  logic [4:0]  rx_count;
  logic        frame_tgl;
  logic [15:0] tx_word;
  modport link (output rx_word, output rx_count, output frame_tgl, input tx_word);
  modport core (input rx_word, input rx_count, input frame_tgl, output tx_word);
endinterface

interface reg_if;
  logic [13:0] addr;
  logic [13:0] wdata;
  logic [13:0] rdata;
  logic        we;
  logic        hit;
  logic        writable;
  modport bank (input addr, input wdata, input we, output rdata, output hit, output writable);
  modport core (output addr, output wdata, output we, input rdata, input hit, input writable);
endinterface

// >>> design/spi_link.sv
// serial shifter running on the host's serial clock
`timescale 1ns/1ps
module spi_link (
  input  wire logic i_spi_clk,
  input  wire logic i_cs_n,
  input  wire logic i_resetn,
  input  wire logic i_mosi,
  output logic      o_miso,
  output logic      o_miso_oe_n,
  frame_if.link     fr
);
  logic [15:0] rx_shift_r;
  logic [4:0]  rx_count_r;
  logic [4:0]  tx_cnt_r;
  logic        tgl_r;

  // capture on falling edge, msb first; count is rising edges seen
  always_ff @(negedge i_spi_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_shift_r <= 16'h0000;
      rx_count_r <= 5'h00;
    end else begin
      rx_shift_r <= {rx_shift_r[14:0], i_mosi}; // R6 R8
      rx_count_r <= tx_cnt_r;
    end
  end

  // drive on rising edge; released while chip select is high
  always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      tx_cnt_r    <= 5'h00;
      o_miso      <= 1'b0;
      o_miso_oe_n <= 1'b1; // R24
    end else begin
      o_miso_oe_n <= 1'b0; // R24
      o_miso      <= (tx_cnt_r < 5'(sensor_spi_pkg::FRAME_BITS)) ?
                     fr.tx_word[4'(4'hf - tx_cnt_r[3:0])] : 1'b0; // R4 R8
      if (tx_cnt_r != 5'h1f) begin
        tx_cnt_r <= tx_cnt_r + 5'h01;
      end
    end
  end

  // one toggle per clocked frame, so empty frames are recognised
  always_ff @(posedge i_spi_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tgl_r <= 1'b0;
    end else if (!i_cs_n && tx_cnt_r == 5'h00) begin
      tgl_r <= ~tgl_r;
    end
  end

  assign fr.rx_word   = rx_shift_r;
  assign fr.rx_count  = rx_count_r;
  assign fr.frame_tgl = tgl_r;
endmodule

// >>> design/sensor_reg_bank.sv
// register bank: writable settings and read multiplexer
`timescale 1ns/1ps
module sensor_reg_bank #(
  parameter int N_WORDS = sensor_spi_pkg::CFG_WORDS
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic [13:0] i_angle_raw,
  input  wire logic [13:0] i_angle_comp,
  input  wire logic [13:0] i_magnitude,
  input  wire logic [13:0] i_diag,
  output logic [13:0]      o_prog,
  output logic [13:0]      o_zero_hi,
  output logic [13:0]      o_zero_lo,
  output logic [13:0]      o_settings1,
  output logic [13:0]      o_settings2,
  reg_if.bank              rg
);
  logic [13:0] cfg_r [N_WORDS];
  logic [2:0]  widx;

  always_comb begin
    rg.hit      = 1'b1;
    rg.writable = 1'b1;
    rg.rdata    = 14'h0000;
    widx        = sensor_spi_pkg::IDX_PROG;
    case (rg.addr)
      sensor_spi_pkg::ADDR_PROG:     rg.rdata = cfg_r[sensor_spi_pkg::IDX_PROG];
      sensor_spi_pkg::ADDR_ZERO_HI: begin
        widx     = sensor_spi_pkg::IDX_ZERO_HI;
        rg.rdata = cfg_r[sensor_spi_pkg::IDX_ZERO_HI];
      end
      sensor_spi_pkg::ADDR_ZERO_LO: begin
        widx     = sensor_spi_pkg::IDX_ZERO_LO;
        rg.rdata = cfg_r[sensor_spi_pkg::IDX_ZERO_LO];
      end
      sensor_spi_pkg::ADDR_SET1: begin
        widx     = sensor_spi_pkg::IDX_SET1;
        rg.rdata = cfg_r[sensor_spi_pkg::IDX_SET1];
      end
      sensor_spi_pkg::ADDR_SET2: begin
        widx     = sensor_spi_pkg::IDX_SET2;
        rg.rdata = cfg_r[sensor_spi_pkg::IDX_SET2];
      end
      sensor_spi_pkg::ADDR_NOP,
      sensor_spi_pkg::ADDR_FAULT:    rg.writable = 1'b0; // R23
      sensor_spi_pkg::ADDR_DIAG: begin
        rg.writable = 1'b0;
        rg.rdata    = i_diag;
      end
      sensor_spi_pkg::ADDR_MAG: begin
        rg.writable = 1'b0;
        rg.rdata    = i_magnitude;
      end
      sensor_spi_pkg::ADDR_ANG_RAW: begin
        rg.writable = 1'b0;
        rg.rdata    = i_angle_raw;
      end
      sensor_spi_pkg::ADDR_ANG_COMP: begin
        rg.writable = 1'b0;
        rg.rdata    = i_angle_comp;
      end
      default: begin
        rg.hit      = 1'b0; // R21
        rg.writable = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < N_WORDS; i++) begin
        cfg_r[i] <= (i == int'(sensor_spi_pkg::IDX_SET1)) ?
                    sensor_spi_pkg::RST_SET1 : sensor_spi_pkg::RST_CFG;
      end
    end else if (rg.we && rg.writable) begin
      cfg_r[widx] <= rg.wdata; // R17
    end
  end

  assign o_prog      = cfg_r[sensor_spi_pkg::IDX_PROG];
  assign o_zero_hi   = cfg_r[sensor_spi_pkg::IDX_ZERO_HI];
  assign o_zero_lo   = cfg_r[sensor_spi_pkg::IDX_ZERO_LO];
  assign o_settings1 = cfg_r[sensor_spi_pkg::IDX_SET1];
  assign o_settings2 = cfg_r[sensor_spi_pkg::IDX_SET2];
endmodule

// >>> design/sensor_spi_slave.sv
// top of the sensor serial slave: frame decoding, faults and pipelined answers
// How it works
// [R1] host ignores angle values until the 10 ms power-on time has passed
// [R2] device is slave only; it never drives serial clock or chip select
// [R3] host keeps serial clock at or below 10 MHz
// [R4] mode 1: clock idles low, data captured on trailing clock edge
// [R5] host starts a frame by lowering chip select with clock low
// [R6] incoming bits are captured on the falling serial clock edge
// [R7] a frame is acted on only when chip select rises
// [R8] all frames shift most significant bit first
// [R9] a transaction is a command frame then a data frame, each own select
// [R10] command bit 14 selects read (1) or write (0), bits 13:0 address
// [R11] host sets command bit 15 for even parity over lower fifteen bits
// [R12] wrong command parity sets the parity fault flag
// [R13] answer: data in 13:0, error in bit 14, even parity in bit 15
// [R14] answer error bit is high when the previous command had an error
// [R15] read value latched at select rise, shifted out in the next frame
// [R16] write data: value in 13:0, bit 14 low, bit 15 even parity
// [R17] write data frame is stored into the address of the prior command
// [R18] during write data frame the old register value is shifted out
// [R19] frame after write data returns the newly written value
// [R20] reading the fault status register returns flags then clears it
// [R21] access to a missing address sets the bad address flag
// [R22] a non-compliant frame sets the framing fault flag
// [R23] reading address zero has no side effect
// [R24] serial output is released whenever chip select is high
// [R25] after reset the pending answer and error bit are zero
`timescale 1ns/1ps
module sensor_spi_slave (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_spi_clk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic [13:0] i_angle_raw,
  input  wire logic [13:0] i_angle_comp,
  input  wire logic [13:0] i_magnitude,
  input  wire logic [13:0] i_diag,
  output logic             o_miso,
  output logic             o_miso_oe_n,
  output logic [13:0]      o_prog,
  output logic [13:0]      o_zero_hi,
  output logic [13:0]      o_zero_lo,
  output logic [13:0]      o_settings1,
  output logic [13:0]      o_settings2,
  output logic [2:0]       o_fault_flags,
  output logic             o_frame_done
);
  frame_if fr ();
  reg_if   rg ();

  // the link end only listens to clock and select; it never drives them
  spi_link u_link ( // R2
    .i_spi_clk   (i_spi_clk),
    .i_cs_n      (i_cs_n),
    .i_resetn    (i_resetn),
    .i_mosi      (i_mosi),
    .o_miso      (o_miso),
    .o_miso_oe_n (o_miso_oe_n),
    .fr          (fr.link)
  );

  sensor_reg_bank u_bank (
    .i_clk_sys    (i_clk_sys),
    .i_resetn     (i_resetn),
    .i_angle_raw  (i_angle_raw),
    .i_angle_comp (i_angle_comp),
    .i_magnitude  (i_magnitude),
    .i_diag       (i_diag),
    .o_prog       (o_prog),
    .o_zero_hi    (o_zero_hi),
    .o_zero_lo    (o_zero_lo),
    .o_settings1  (o_settings1),
    .o_settings2  (o_settings2),
    .rg           (rg.bank)
  );

  logic [2:0]  cs_sync_r;
  logic [2:0]  tgl_sync_r;
  logic        cs_high_r;
  logic        tgl_level_r;
  logic        tgl_used_r;
  logic        pend_r;
  logic [13:0] pend_addr_r;
  logic        err_r;
  logic [13:0] resp_r;
  logic [15:0] tx_r;
  logic [2:0]  fault_r;

  logic        cs_rise;
  logic        frame_end;
  logic        good_len;
  logic [15:0] rx;
  logic [13:0] rd_val;
  logic [2:0]  fault_set;
  logic        fault_rd;
  logic        err_nxt;
  logic [13:0] resp_nxt;
  logic        pend_nxt;
  logic        wr_en;

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_sync_r  <= sensor_spi_pkg::RST_SYNC_HI;
      tgl_sync_r <= 3'h0;
    end else begin
      cs_sync_r  <= {cs_sync_r[1:0], i_cs_n};
      tgl_sync_r <= {tgl_sync_r[1:0], fr.frame_tgl};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_high_r   <= 1'b1;
      tgl_level_r <= 1'b0;
    end else begin
      if (cs_sync_r[1] == cs_sync_r[2]) begin
        cs_high_r <= cs_sync_r[2];
      end
      if (tgl_sync_r[1] == tgl_sync_r[2]) begin
        tgl_level_r <= tgl_sync_r[2];
      end
    end
  end

  assign cs_rise   = (cs_sync_r[1] == cs_sync_r[2]) && cs_sync_r[2] && !cs_high_r;
  assign frame_end = cs_rise; // R7

  // received word is quiet once select is high, so it is read here directly
  assign rx       = fr.rx_word;
  assign good_len = (fr.rx_count == 5'(sensor_spi_pkg::FRAME_BITS)) &&
                    (tgl_level_r != tgl_used_r); // R9 R22

  assign rg.addr  = pend_r ? pend_addr_r : rx[13:0]; // R10 R17
  assign rg.wdata = rx[13:0];
  assign rg.we    = frame_end && wr_en;
  assign rd_val   = (rg.addr == sensor_spi_pkg::ADDR_FAULT) ?
                    {11'h000, fault_r} : rg.rdata; // R20

  always_comb begin
    fault_set = 3'h0;
    fault_rd  = 1'b0;
    err_nxt   = err_r;
    resp_nxt  = resp_r;
    pend_nxt  = pend_r;
    wr_en     = 1'b0;
    if (!good_len) begin
      fault_set[sensor_spi_pkg::FAULT_FRAME] = 1'b1; // R22
      err_nxt  = 1'b1;
      pend_nxt = 1'b0;
    end else if (pend_r) begin
      pend_nxt = 1'b0;
      if (sensor_spi_pkg::parity15(rx[14:0]) != rx[sensor_spi_pkg::BIT_PARITY]) begin
        fault_set[sensor_spi_pkg::FAULT_PARITY] = 1'b1;
        err_nxt = 1'b1;
      end else if (rx[sensor_spi_pkg::BIT_DIR]) begin
        fault_set[sensor_spi_pkg::FAULT_FRAME] = 1'b1; // R22
        err_nxt = 1'b1;
      end else begin
        wr_en    = 1'b1; // R17
        resp_nxt = rx[13:0]; // R19
        err_nxt  = 1'b0;
      end
    end else if (sensor_spi_pkg::parity15(rx[14:0]) != rx[sensor_spi_pkg::BIT_PARITY]) begin
      fault_set[sensor_spi_pkg::FAULT_PARITY] = 1'b1; // R12
      err_nxt = 1'b1; // R14
    end else if (!rg.hit) begin
      fault_set[sensor_spi_pkg::FAULT_ADDR] = 1'b1; // R21
      err_nxt  = 1'b1; // R14
      resp_nxt = 14'h0000;
    end else if (rx[sensor_spi_pkg::BIT_DIR]) begin
      resp_nxt = rd_val; // R15
      err_nxt  = 1'b0;
      fault_rd = (rg.addr == sensor_spi_pkg::ADDR_FAULT); // R20
    end else if (!rg.writable) begin
      fault_set[sensor_spi_pkg::FAULT_ADDR] = 1'b1; // R21
      err_nxt = 1'b1;
    end else begin
      pend_nxt = 1'b1;
      resp_nxt = rd_val; // R18
      err_nxt  = 1'b0;
    end
  end

  // frame bookkeeping and pipelined answer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tgl_used_r  <= 1'b0;
      pend_r      <= 1'b0;
      pend_addr_r <= sensor_spi_pkg::ADDR_NOP;
      err_r       <= 1'b0; // R25
      resp_r      <= 14'h0000; // R25
      tx_r        <= sensor_spi_pkg::RST_TX; // R25
    end else if (frame_end) begin
      tgl_used_r  <= tgl_level_r;
      pend_r      <= pend_nxt;
      pend_addr_r <= rx[13:0];
      err_r       <= err_nxt;
      resp_r      <= resp_nxt;
      tx_r        <= {sensor_spi_pkg::parity15({err_nxt, resp_nxt}),
                      err_nxt, resp_nxt}; // R13 R14
    end
  end

  // fault flags: a new event wins over the clear of a read
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_r <= 3'h0;
    end else if (frame_end) begin
      fault_r <= (fault_rd ? 3'h0 : fault_r) | fault_set; // R20 R12
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= frame_end;
    end
  end

  assign fr.tx_word    = tx_r;
  assign o_fault_flags = fault_r;
endmodule

// >>> test/sensor_spi_slave_assertions.sv
// concurrent checks on the serial slave's ports
`timescale 1ns/1ps
module sensor_spi_slave_assertions (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        i_spi_clk,
  input wire logic        i_cs_n,
  input wire logic        o_miso,
  input wire logic        o_miso_oe_n,
  input wire logic [13:0] o_settings1,
  input wire logic [13:0] o_settings2,
  input wire logic [2:0]  o_fault_flags,
  input wire logic        o_frame_done
);
  sequence s_frame_end;
    $rose(i_cs_n);
  endsequence
  sequence s_done_soon;
    ##[2:8] o_frame_done ##1 !o_frame_done;
  endsequence
  a_done_after_end: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn) s_frame_end |-> s_done_soon)
    else $error("frame not completed after select rise");
  a_done_single: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn) o_frame_done |=> !o_frame_done)
    else $error("frame done longer than one cycle");
  a_done_when_idle: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn) o_frame_done |-> i_cs_n && $past(i_cs_n, 2))
    else $error("frame done while select low");
  a_flags_frozen: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn) !i_cs_n |=> $stable(o_fault_flags))
    else $error("fault flags moved inside a frame");
  a_setting_frozen: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !i_cs_n |=> $stable(o_settings1) && $stable(o_settings2))
    else $error("settings written inside a frame");
  a_released_idle: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn) i_cs_n |-> o_miso_oe_n)
    else $error("serial out driven while deselected");
  a_drive_in_frame: assert property (
    @(negedge i_spi_clk) disable iff (!i_resetn) !i_cs_n |-> !o_miso_oe_n)
    else $error("serial out not driven at capture edge");
  a_miso_held: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    !i_cs_n && $stable(i_spi_clk) && $stable(i_cs_n) |-> $stable(o_miso))
    else $error("serial out changed away from rising clock");
endmodule

bind sensor_spi_slave sensor_spi_slave_assertions chk_inst (
  .i_clk_sys, .i_resetn, .i_spi_clk, .i_cs_n, .o_miso, .o_miso_oe_n,
  .o_settings1, .o_settings2, .o_fault_flags, .o_frame_done
);

// >>> test/spi_host_model.sv
// host-side serial master model issuing mode 1 frames
`timescale 1ns/1ps
module spi_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_mosi = 1'b1;
    // early select rise puts serial out in its released state
    #1 o_cs_n = 1'b1;
  end
  // n bits of w out, reply in r, select then held high for gap ns
  task automatic xfer(input logic [15:0] w, input int n, input int gap,
                      output logic [15:0] r);
    r = 16'h0000;
    #3 o_cs_n = 1'b0;
    #400;
    for (int i = 15; i > 15 - n; i--) begin
      o_sclk = 1'b1;
      o_mosi = w[i];
      #50 o_sclk = 1'b0;
      r = {r[14:0], i_miso};
      #50;
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #(gap);
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the sensor serial slave
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  logic        clk;
  logic        resetn;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe_n;
  wire         miso_w;
  logic [13:0] rv[4];
  logic [13:0] ra[4];
  logic [13:0] settings1;
  logic [13:0] settings2;
  logic [13:0] prog;
  logic [13:0] zero_hi;
  logic [13:0] zero_lo;
  logic [2:0]  fault;
  int          err_total;
  int          checked;

  assign miso_w = miso_oe_n ? 1'bz : miso;

  sensor_spi_slave sensor_spi_slave_inst (
    .i_clk_sys(clk), .i_resetn(resetn), .i_spi_clk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_angle_raw(rv[0]), .i_angle_comp(rv[1]), .i_magnitude(rv[2]),
    .i_diag(rv[3]), .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_prog(prog),
    .o_zero_hi(zero_hi), .o_zero_lo(zero_lo), .o_settings1(settings1),
    .o_settings2(settings2),
    .o_fault_flags(fault), .o_frame_done()
  );

  spi_host_model spi_host_model_inst (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_w)
  );

  function automatic logic [15:0] word(input logic b14, input logic [13:0] v);
    return {^{b14, v}, b14, v};
  endfunction

  task automatic fr(input logic [15:0] w, input logic [15:0] exp,
                    input logic [15:0] m = 16'hffff, input int n = 16);
    logic [15:0] r;
    spi_host_model_inst.xfer(w, n, 500, r);
    `CHK(r & m, exp & m)
  endtask

  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    err_total = 0;
    checked = 0;
    resetn = 1'b0;
    rv = '{14'h0000, 14'h0000, 14'h0000, 14'h0000};
    ra = '{14'h3ffe, 14'h3fff, 14'h3ffd, 14'h3ffc};
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rv <= '{14'h1a5b, 14'h2c3d, 14'h0f1e, 14'h0180};
    repeat (4) @(posedge clk);
    fr(word(1, 14'h0000), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      fr(word(1, ra[i]), (i > 0) ? word(0, rv[(i + 3) % 4]) : 16'h0000);
    end
    fr(word(0, sensor_spi_pkg::ADDR_SET1), word(0, rv[3]));
    fr(word(0, 14'h2a5c), word(0, 14'h0001));
    `CHK(settings1, 14'h2a5c)
    fr(word(1, 14'h0000), word(0, 14'h2a5c));
    `CHK(miso_oe_n, 1'b1)
    fr(word(1, 14'h3ffe) ^ 16'h8000, 16'h0000);
    fr(word(1, 14'h0000), 16'h4000, 16'h4000);
    `CHK(fault[2], 1'b1)
    fr(word(1, 14'h0005), 16'h0000);
    fr(word(1, 14'h0000), word(1, 14'h0000));
    `CHK(fault[1], 1'b1)
    fr(word(1, 14'h0000), 16'h0000, 16'h0000, 15);
    `CHK(fault[0], 1'b1)
    fr(word(1, sensor_spi_pkg::ADDR_FAULT), 16'h4000, 16'h4000);
    fr(word(1, 14'h0000), word(0, 14'h0007));
    `CHK(fault, 3'h0)
    fr(word(1, 14'h0000), 16'h0000);
    fr(word(0, sensor_spi_pkg::ADDR_SET2), 16'h0000);
    fr(word(0, 14'h1234), word(0, 14'h0000));
    `CHK(settings2, 14'h1234)
    `CHK({prog, zero_hi, zero_lo}, 42'h0)
    fr(word(1, 14'h0000), word(0, 14'h1234));
    summarize();
  end
endmodule
